// File: verilog/pamux_pkg.sv
// Package for the port 3 / port 1 alternate-function multiplexer.
// Assumes a single synchronous clock domain.
package pamux_pkg;
   localparam int PORT_W = 8;
   localparam logic [7:0] LATCH_RST = 8'hff;
   // Reset and idle levels of the pad cells
   localparam logic IN_IDLE = 1'b1;
   localparam logic OE_RST = 1'b0;
   localparam logic PAD_LOW = 1'b0;
   // Port 3 bit positions
   localparam int P3_RX_BIT = 0;
   localparam int P3_TX_BIT = 1;
   localparam int P3_EXT_INTERRUPT_ZERO_IN_BIT = 2;
   localparam int P3_EXT_INTERRUPT_ONE_IN_BIT = 3;
   localparam int P3_CNT0_BIT = 4;
   localparam int P3_CNT1_BIT = 5;
   localparam int P3_WR_BIT = 6;
   localparam int P3_RD_BIT = 7;
   // Port 1 bit positions
   localparam int P1_CC_LO_BIT = 0;
   localparam int P1_CC_N = 4;
   localparam int P1_EXT_INTERRUPT_TWO_IN_BIT = 4;
   localparam int P1_RELOAD_BIT = 5;
   localparam int P1_SYSTEM_CLOCK_OUTPUT_BIT = 6;
   localparam int P1_CNT2_BIT = 7;
endpackage

// File: verilog/pamux_qpin.sv
// One quasi-bidirectional pad cell with an alternate output.
// Assumes the pad wire is resolved outside from oe and out.
`timescale 1ns/1ps
`default_nettype none
module pamux_qpin
   import pamux_pkg::*;
#(
   parameter logic IDLE_LEVEL = IN_IDLE
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic latch_i,
   input wire logic alt_i,
   input wire logic force_i,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic pin_in_o
);
   logic drive_low;
   // Latch zero pulls low unless a forcing function owns the pin
   always_comb begin
      if (force_i) begin
         drive_low = ~alt_i;
      end else begin
         drive_low = ~(latch_i & alt_i);
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_oe_o <= OE_RST;
         pin_o <= PAD_LOW;
         pin_in_o <= IDLE_LEVEL;
      end else begin
         pin_oe_o <= drive_low;
         pin_o <= PAD_LOW;
         pin_in_o <= pin_i;
      end
   end
endmodule
`default_nettype wire

// File: verilog/pamux_top.sv
// Alternate-function multiplexer for two quasi-bidirectional ports.
// Assumes peripherals and latches sit on clk_i; pins externally resolved
// with a weak pull-up wherever the output enable is low.
// Every output is registered; pads follow the inputs one cycle late.
`timescale 1ns/1ps
`default_nettype none
module pamux_top
   import pamux_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [PORT_W-1:0] p3_latch_i,
   input wire logic [PORT_W-1:0] p1_latch_i,
   input wire logic verify_mode_i,
   input wire logic [PORT_W-1:0] verify_addr_lo_i,
   input wire logic serial_sync_mode_i,
   input wire logic serial_rx_data_out_i,
   input wire logic serial_tx_data_i,
   input wire logic serial_shift_clk_i,
   input wire logic xmem_wr_strobe_n_i,
   input wire logic xmem_rd_strobe_n_i,
   input wire logic [P1_CC_N-1:0] compare_en_i,
   input wire logic [P1_CC_N-1:0] compare_out_i,
   input wire logic system_clock_output_en_i,
   input wire logic system_clock_output_i,
   input wire logic [PORT_W-1:0] p3_pin_i,
   output logic [PORT_W-1:0] p3_pin_o,
   output logic [PORT_W-1:0] p3_pin_oe_o,
   input wire logic [PORT_W-1:0] p1_pin_i,
   output logic [PORT_W-1:0] p1_pin_o,
   output logic [PORT_W-1:0] p1_pin_oe_o,
   output logic [PORT_W-1:0] p3_read_o,
   output logic [PORT_W-1:0] p1_read_o,
   output logic serial_rx_in_o,
   output logic ext_interrupt_zero_in_o,
   output logic ext_interrupt_one_in_o,
   output logic counter_zero_event_in_o,
   output logic counter_one_event_in_o,
   output logic [P1_CC_N-1:0] irq_capcomp_in_o,
   output logic ext_interrupt_two_in_o,
   output logic timer_two_reload_trigger_o,
   output logic counter_two_event_in_o
);
   logic [PORT_W-1:0] p3_alt;
   logic [PORT_W-1:0] p1_alt;
   logic [PORT_W-1:0] p1_force;
   logic [PORT_W-1:0] p1_latch_eff;
   // Pad levels after each cell's input flop
   logic [PORT_W-1:0] p3_in_sync;
   logic [PORT_W-1:0] p1_in_sync;

   // First port alternate output values; input-only functions idle high
   always_comb begin
      p3_alt = '1;
      p3_alt[P3_RX_BIT] = serial_sync_mode_i ?
                          serial_rx_data_out_i : 1'b1;
      p3_alt[P3_TX_BIT] = serial_sync_mode_i ?
                          serial_shift_clk_i : serial_tx_data_i;
      p3_alt[P3_WR_BIT] = xmem_wr_strobe_n_i;
      p3_alt[P3_RD_BIT] = xmem_rd_strobe_n_i;
   end

   // Second port alternate outputs; verify mode presents low address
   always_comb begin
      p1_alt = '1;
      p1_force = '0;
      p1_latch_eff = p1_latch_i;
      for (int i = 0; i < P1_CC_N; i++) begin
         if (compare_en_i[i]) begin
            p1_alt[P1_CC_LO_BIT + i] = compare_out_i[i];
            p1_force[P1_CC_LO_BIT + i] = 1'b1;
         end
      end
      if (system_clock_output_en_i) begin
         p1_alt[P1_SYSTEM_CLOCK_OUTPUT_BIT] = system_clock_output_i;
      end
      if (verify_mode_i) begin
         p1_alt = verify_addr_lo_i;
         p1_force = '1;
      end
   end

   // One pad cell per pin; the first port has no forced functions
   genvar g;
   generate
      for (g = 0; g < PORT_W; g++) begin : g_pins
         pamux_qpin u_p3 (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .latch_i(p3_latch_i[g]),
            .alt_i(p3_alt[g]),
            .force_i(1'b0),
            .pin_i(p3_pin_i[g]),
            .pin_o(p3_pin_o[g]),
            .pin_oe_o(p3_pin_oe_o[g]),
            .pin_in_o(p3_in_sync[g])
         );
         pamux_qpin u_p1 (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .latch_i(p1_latch_eff[g]),
            .alt_i(p1_alt[g]),
            .force_i(p1_force[g]),
            .pin_i(p1_pin_i[g]),
            .pin_o(p1_pin_o[g]),
            .pin_oe_o(p1_pin_oe_o[g]),
            .pin_in_o(p1_in_sync[g])
         );
      end
   endgenerate

   // Core view of the pad levels on both ports
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         p3_read_o <= {PORT_W{IN_IDLE}};
      end else begin
         p3_read_o <= p3_in_sync;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         p1_read_o <= {PORT_W{IN_IDLE}};
      end else begin
         p1_read_o <= p1_in_sync;
      end
   end

   // First port input functions
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         serial_rx_in_o <= IN_IDLE;
      end else begin
         serial_rx_in_o <= p3_in_sync[P3_RX_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ext_interrupt_zero_in_o <= IN_IDLE;
      end else begin
         ext_interrupt_zero_in_o <= p3_in_sync[P3_EXT_INTERRUPT_ZERO_IN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ext_interrupt_one_in_o <= IN_IDLE;
      end else begin
         ext_interrupt_one_in_o <= p3_in_sync[P3_EXT_INTERRUPT_ONE_IN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         counter_zero_event_in_o <= IN_IDLE;
      end else begin
         counter_zero_event_in_o <= p3_in_sync[P3_CNT0_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         counter_one_event_in_o <= IN_IDLE;
      end else begin
         counter_one_event_in_o <= p3_in_sync[P3_CNT1_BIT];
      end
   end

   // Second port input functions
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_capcomp_in_o <= {P1_CC_N{IN_IDLE}};
      end else begin
         irq_capcomp_in_o <= p1_in_sync[P1_CC_LO_BIT +: P1_CC_N];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ext_interrupt_two_in_o <= IN_IDLE;
      end else begin
         ext_interrupt_two_in_o <= p1_in_sync[P1_EXT_INTERRUPT_TWO_IN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         timer_two_reload_trigger_o <= IN_IDLE;
      end else begin
         timer_two_reload_trigger_o <= p1_in_sync[P1_RELOAD_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         counter_two_event_in_o <= IN_IDLE;
      end else begin
         counter_two_event_in_o <= p1_in_sync[P1_CNT2_BIT];
      end
   end
endmodule
`default_nettype wire

// File: test/pamux_top_props.sv
// Checker of pad enables and input paths of the pin multiplexer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pamux_top_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] p3_latch_i,
   input wire logic [7:0] p1_latch_i,
   input wire logic verify_mode_i,
   input wire logic [7:0] verify_addr_lo_i,
   input wire logic xmem_wr_strobe_n_i,
   input wire logic xmem_rd_strobe_n_i,
   input wire logic [3:0] compare_en_i,
   input wire logic [3:0] compare_out_i,
   input wire logic [7:0] p3_pin_i,
   input wire logic [7:0] p1_pin_i,
   input wire logic [7:0] p3_pin_oe_o,
   input wire logic [7:0] p1_pin_oe_o,
   input wire logic [7:0] p3_read_o,
   input wire logic timer_two_reload_trigger_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_wr;
      p3_latch_i[6] && !xmem_wr_strobe_n_i |=> p3_pin_oe_o[6];
   endproperty
   a_wr: assert property (p_wr) else $error("write strobe lost");
   property p_rd;
      p3_latch_i[7] && xmem_rd_strobe_n_i |=> !p3_pin_oe_o[7];
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe stuck");
   property p_lat; !p3_latch_i[2] |=> p3_pin_oe_o[2]; endproperty
   a_lat: assert property (p_lat) else $error("zero latch not low");
   property p_cmp; compare_en_i[0] && !verify_mode_i && !p1_latch_i[0]
      |=> p1_pin_oe_o[0] != $past(compare_out_i[0]); endproperty
   a_cmp: assert property (p_cmp) else $error("compare not forced");
   property p_ver; verify_mode_i |=> p1_pin_oe_o == ~$past(verify_addr_lo_i);
   endproperty
   a_ver: assert property (p_ver) else $error("verify address");
   property p_rld;
      !p1_pin_i[5] |-> ##2 !timer_two_reload_trigger_o;
   endproperty
   a_rld: assert property (p_rld) else $error("reload trigger");
   property p_in3; 1'b1 |-> ##2 p3_read_o == $past(p3_pin_i, 2); endproperty
   a_in3: assert property (p_in3) else $error("port read");
   property p_c2;
      p1_latch_i[7] && !verify_mode_i |=> !p1_pin_oe_o[7];
   endproperty
   a_c2: assert property (p_c2) else $error("counter pin not high");
endmodule
bind pamux_top pamux_top_props chk_u (.*);
`default_nettype wire

// File: test/pamux_board.sv
// Board model: weak pull-ups on both ports and open-drain pull-downs.
// Assumes the bench chooses which lines the board pulls low.
`timescale 1ns/1ps
`default_nettype none
module pamux_board (
   input wire logic [7:0] oe3_i,
   input wire logic [7:0] oe1_i,
   input wire logic [7:0] low3_i,
   input wire logic [7:0] low1_i,
   output logic [7:0] pin3_o,
   output logic [7:0] pin1_o
);
   assign pin3_o = ~(oe3_i | low3_i);
   assign pin1_o = ~(oe1_i | low1_i);
endmodule
`default_nettype wire

// File: test/test_pamux_top.sv
// Bench: random pin traffic compared with an integer model each cycle.
// Assumes the board model resolves the pads.
`timescale 1ns/1ps
`default_nettype none
module test_pamux_top import pamux_pkg::*; ;
   logic clk_i, sys_rst_i, verify_mode_i, serial_sync_mode_i, system_clock_output_en_i;
   logic serial_rx_data_out_i, serial_tx_data_i, serial_shift_clk_i;
   logic xmem_wr_strobe_n_i, xmem_rd_strobe_n_i, system_clock_output_i;
   logic [7:0] p3_latch_i, p1_latch_i, verify_addr_lo_i, p3_pin_i, p1_pin_i;
   logic [7:0] p3_pin_o, p1_pin_o, p3_pin_oe_o, p1_pin_oe_o;
   logic [7:0] p3_read_o, p1_read_o, lo3, lo1;
   logic [3:0] compare_en_i, compare_out_i, irq_capcomp_in_o;
   logic serial_rx_in_o, ext_interrupt_zero_in_o, ext_interrupt_one_in_o;
   logic counter_zero_event_in_o, counter_one_event_in_o;
   logic ext_interrupt_two_in_o, timer_two_reload_trigger_o;
   logic counter_two_event_in_o;
   logic [15:0] e, w, f, q[$];
   int fail_count, n_tests, seed, k;
   pamux_top dut_u (.*);
   pamux_board board_u (.oe3_i(p3_pin_oe_o), .oe1_i(p1_pin_oe_o),
      .low3_i(lo3), .low1_i(lo1), .pin3_o(p3_pin_i), .pin1_o(p1_pin_i));
   task chk(input logic [15:0] seen, input logic [15:0] exp, string what);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task drive(input logic [63:0] r);
      {p3_latch_i, p1_latch_i, verify_addr_lo_i, lo3, lo1, compare_en_i,
       compare_out_i, serial_sync_mode_i, serial_rx_data_out_i,
       serial_tx_data_i, serial_shift_clk_i, xmem_wr_strobe_n_i,
       xmem_rd_strobe_n_i, system_clock_output_en_i, system_clock_output_i} = r[55:0];
      verify_mode_i = &r[58:56];
   endtask
   function logic [15:0] exp_oe();
      logic [7:0] a3, a1;
      a3 = {xmem_rd_strobe_n_i, xmem_wr_strobe_n_i, 4'hf,
         serial_sync_mode_i ? serial_shift_clk_i : serial_tx_data_i,
         serial_sync_mode_i ? serial_rx_data_out_i : 1'b1};
      a1 = {1'b1, system_clock_output_en_i ? system_clock_output_i : 1'b1, 2'b11,
         compare_out_i | ~compare_en_i};
      if (verify_mode_i)
         return {~(p3_latch_i & a3), ~verify_addr_lo_i};
      return {~(p3_latch_i & a3), ~((p1_latch_i | {4'h0, compare_en_i}) & a1)};
   endfunction
   task finish_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   wire [15:0] oe = {p3_pin_oe_o, p1_pin_oe_o};
   wire [15:0] fn = {4'h0, serial_rx_in_o, ext_interrupt_zero_in_o,
      ext_interrupt_one_in_o, counter_zero_event_in_o, counter_one_event_in_o,
      irq_capcomp_in_o, ext_interrupt_two_in_o, timer_two_reload_trigger_o,
      counter_two_event_in_o};
   initial begin
      clk_i = 0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      seed = 32'h3a34;
      sys_rst_i = 1;
      drive('0);
      repeat (12) @(negedge clk_i);
      chk(oe, 16'h0000, "reset oe");
      chk({p3_pin_o, p1_pin_o}, 16'h0000, "reset pad");
      chk({p3_read_o, p1_read_o}, 16'hffff, "reset read");
      chk(fn, 16'h0fff, "reset inputs");
      $display("test reset done");
      sys_rst_i = 0;
      for (k = 0; k < 3000; k++) begin
         drive({$random(seed), $random(seed)});
         e = exp_oe();
         #1 q.push_back({p3_pin_i, p1_pin_i});
         @(negedge clk_i);
         chk(oe, e, "oe");
         chk({p3_pin_o, p1_pin_o}, 16'h0000, "pad");
         if (q.size() == 2) begin
            w = q.pop_front();
            f = {4'h0, w[8], w[10], w[11], w[12], w[13], w[3:0], w[4], w[5],
               w[7]};
            chk({p3_read_o, p1_read_o}, w, "read");
            chk(fn, f, "inputs");
         end
      end
      $display("test random done");
      finish_test();
   end
endmodule
`default_nettype wire
